// file: core/dsmb_pkg.sv
// package: register map, status bit positions, modes and reset values of the drive status block
package dsmb_pkg;

  localparam int DSMB_DATA_W = 32;
  localparam int DSMB_ADDR_W = 12;
  localparam int DSMB_CNT_W  = 16;
  localparam int DSMB_IRQ_N  = 4;

  // register byte offsets
  localparam logic [11:0] DSMB_OFF_STATUS   = 12'h000;
  localparam logic [11:0] DSMB_OFF_FERR_WIN = 12'h004;
  localparam logic [11:0] DSMB_OFF_FERR_TMO = 12'h008;
  localparam logic [11:0] DSMB_OFF_POS_WIN  = 12'h00C;
  localparam logic [11:0] DSMB_OFF_VEL_WIN  = 12'h010;
  localparam logic [11:0] DSMB_OFF_VEL_TIME = 12'h014;
  localparam logic [11:0] DSMB_OFF_VEL_THR  = 12'h018;
  localparam logic [11:0] DSMB_OFF_IRQ_STS  = 12'h01C;
  localparam logic [11:0] DSMB_OFF_IRQ_CLR  = 12'h020;
  localparam logic [11:0] DSMB_OFF_IRQ_EN   = 12'h024;

  // reset values
  localparam logic [31:0] DSMB_RST_FERR_WIN = 32'h0000_0100;
  localparam logic [31:0] DSMB_RST_FERR_TMO = 32'h0000_0064;
  localparam logic [31:0] DSMB_RST_POS_WIN  = 32'h0000_0010;
  localparam logic [31:0] DSMB_RST_VEL_WIN  = 32'h0000_0020;
  localparam logic [31:0] DSMB_RST_VEL_TIME = 32'h0000_0064;
  localparam logic [31:0] DSMB_RST_VEL_THR  = 32'h0000_0040;
  localparam logic [3:0]  DSMB_RST_IRQ_EN   = 4'h0;

  // status word bit positions
  localparam int DSMB_SW_TOL     = 8;
  localparam int DSMB_SW_TARGET  = 10;
  localparam int DSMB_SW_HOME    = 11;
  localparam int DSMB_SW_ACK     = 12;
  localparam int DSMB_SW_STOPPED = 13;
  localparam int DSMB_SW_LIM_POS = 15;
  localparam int DSMB_SW_LIM_OTH = 11;

  // control word bit positions
  localparam int DSMB_CW_TASK = 6;
  localparam int DSMB_CW_HALT = 8;

  // interrupt status bit positions
  localparam int DSMB_IRQ_FERR   = 0;
  localparam int DSMB_IRQ_TARGET = 1;
  localparam int DSMB_IRQ_ACK    = 2;
  localparam int DSMB_IRQ_LIMIT  = 3;

  typedef enum logic [1:0] {
    DSMB_MODE_NONE = 2'h0,
    DSMB_MODE_POS  = 2'h1,
    DSMB_MODE_VEL  = 2'h3,
    DSMB_MODE_TRQ  = 2'h2
  } dsmb_mode_t;

endpackage

// file: core/dsmb_win_if.sv
// interface: condition, limit and result between the status logic and a hold timer
`timescale 1ns/10ps
interface dsmb_win_if #(
  parameter int CNT_W = 16
);
  logic             cond;
  logic [CNT_W-1:0] limit;
  logic             held;

  modport user  (output cond, output limit, input held);
  modport timer (input cond, input limit, output held);
endinterface

// file: core/dsmb_hold_timer.sv
// module: reports that a condition has stood for longer than a cycle limit
`timescale 1ns/10ps
module dsmb_hold_timer
  import dsmb_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   sys_rst,
  // condition and result
  dsmb_win_if.timer   win
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             held;
  } dsmb_tmr_t;

  dsmb_tmr_t r;
  dsmb_tmr_t next_r;

  always_comb begin
    next_r = r;
    if (!win.cond) begin
      next_r.count = '0;
      next_r.held  = 1'b0;
    end else begin
      // saturating count of cycles the condition has already stood
      if (r.count != {CNT_W{1'b1}}) begin
        next_r.count = r.count + 1'b1;
      end
      next_r.held = (r.count >= win.limit);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign win.held = r.held;

  property p_drop;
    @(posedge clk) disable iff (sys_rst)
    !win.cond |=> !win.held;
  endproperty
  a_drop: assert property (p_drop) else $error("hold flag survived a dropped condition");

endmodule

// file: core/dsmb_status_bits.sv
// module: mode specific drive status word bits with APB register access and interrupt
// Function
// - position mode: bit 8 clears once following error exceeds window past timeout.
// - position mode: bit 10 set when task ended inside positioning window.
// - position mode: bit 11 set only with a valid home position.
// - position mode: bit 12 rises to acknowledge an accepted traversing task.
// - acknowledge bit answers only the falling edge of control bit 6.
// - outside operation bit 12 is zero; rising control bit 6 rearms it only in operation.
// - position mode: bit 13 low while task moves, high when stopped.
// - internal limit on bit 15 in position mode, bit 11 in velocity and torque modes.
// - velocity mode: bit 8 set when speed error stays inside window past time.
// - velocity mode: bit 10 set when actual velocity at or above threshold.
// - torque mode, halt clear: bit 10 shows target torque reached.
// - torque mode, halt set: bit 10 low decelerating, high once stopped.
// - torque mode, safety stop: bit 10 low, halt bit ignored.
// - internal limit from software limit, either overtravel switch or torque limit.
`timescale 1ns/10ps
module dsmb_status_bits
  import dsmb_pkg::*;
#(
  parameter int CNT_W = DSMB_CNT_W
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // apb slave
  input  wire logic [DSMB_ADDR_W-1:0]  paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [DSMB_DATA_W-1:0]  pwdata,
  output logic      [DSMB_DATA_W-1:0]  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // drive state and control word
  input  wire logic [1:0]              opMode,
  input  wire logic                    inOperation,
  input  wire logic [15:0]             ctrlWord,
  // position path
  input  wire logic signed [31:0]      actPos,
  input  wire logic signed [31:0]      demandPos,
  input  wire logic signed [31:0]      targetPos,
  input  wire logic                    taskActive,
  input  wire logic                    taskDone,
  input  wire logic                    taskAccepted,
  input  wire logic                    homeValid,
  // velocity and torque path
  input  wire logic signed [31:0]      actVel,
  input  wire logic signed [31:0]      targetVel,
  input  wire logic                    torqueReached,
  input  wire logic                    axisStopped,
  input  wire logic                    safetyStopRequest,
  // limit sources
  input  wire logic                    swPosLimit,
  input  wire logic                    posOvertravel,
  input  wire logic                    negOvertravel,
  input  wire logic                    torqueLimit,
  // status and interrupt
  output logic      [15:0]             driveStatusWord,
  output logic                         irq
);

  typedef struct packed {
    logic [31:0]            ferrWin;
    logic [31:0]            ferrTmo;
    logic [31:0]            posWin;
    logic [31:0]            velWin;
    logic [31:0]            velTime;
    logic [31:0]            velThr;
    logic [DSMB_IRQ_N-1:0]  irqSts;
    logic [DSMB_IRQ_N-1:0]  irqEn;
    logic                   cw6Prev;
    logic                   ackArmed;
    logic                   ackPending;
    logic                   ackBit;
    logic                   limPrev;
    logic [15:0]            statusWord;
    logic [31:0]            rdData;
    logic                   rdErr;
  } dsmb_state_t;

  dsmb_state_t r;
  dsmb_state_t next_r;

  dsmb_win_if #(.CNT_W(CNT_W)) ferrWinIf ();
  dsmb_win_if #(.CNT_W(CNT_W)) velWinIf ();

  dsmb_hold_timer #(.CNT_W(CNT_W)) ferrTimer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .win     (ferrWinIf)
  );

  dsmb_hold_timer #(.CNT_W(CNT_W)) velTimer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .win     (velWinIf)
  );

  // magnitude of a signed difference, one bit wider to avoid overflow
  function automatic logic [32:0] absDiff(input logic signed [31:0] a, input logic signed [31:0] b);
    logic signed [32:0] d;
    d = {a[31], a} - {b[31], b};
    absDiff = d[32] ? 33'(-d) : 33'(d);
  endfunction

  logic [32:0] posErr;
  logic [32:0] posDev;
  logic [32:0] velErr;
  logic        inPosWin;
  logic        limitAny;
  logic        cw6Rise;
  logic        cw6Fall;
  logic        halt;
  logic        apbSetup;
  logic        apbWrite;
  logic [DSMB_IRQ_N-1:0] irqEvent;
  logic [DSMB_IRQ_N-1:0] irqClr;

  assign posErr   = absDiff(actPos, demandPos);
  assign posDev   = absDiff(actPos, targetPos);
  assign velErr   = absDiff(targetVel, actVel);
  assign inPosWin = (posDev <= {1'b0, r.posWin});
  assign limitAny = swPosLimit | posOvertravel | negOvertravel | torqueLimit;
  assign cw6Rise  = ctrlWord[DSMB_CW_TASK] & ~r.cw6Prev;
  assign cw6Fall  = ~ctrlWord[DSMB_CW_TASK] & r.cw6Prev;
  assign halt     = ctrlWord[DSMB_CW_HALT];
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;

  // timers watch the window conditions
  assign ferrWinIf.cond  = (posErr > {1'b0, r.ferrWin});
  assign ferrWinIf.limit = r.ferrTmo[CNT_W-1:0];
  assign velWinIf.cond   = (velErr <= {1'b0, r.velWin});
  assign velWinIf.limit  = r.velTime[CNT_W-1:0];

  always_comb begin
    next_r   = r;
    irqEvent = '0;
    irqClr   = '0;

    // traversing task acknowledge handshake
    next_r.cw6Prev = ctrlWord[DSMB_CW_TASK];
    if (!inOperation) begin
      next_r.ackBit     = 1'b0;
      next_r.ackArmed   = 1'b0;
      next_r.ackPending = 1'b0;
    end else begin
      if (taskAccepted) begin
        next_r.ackPending = 1'b1;
      end
      if (cw6Rise) begin
        // a new request rearms and withdraws the previous acknowledge
        next_r.ackArmed = 1'b1;
        next_r.ackBit   = 1'b0;
      end else if (cw6Fall && r.ackArmed && (r.ackPending || taskAccepted)) begin
        next_r.ackBit     = 1'b1;
        next_r.ackArmed   = 1'b0;
        next_r.ackPending = 1'b0;
      end
    end

    // mode specific status bits, all others read zero
    next_r.statusWord = '0;
    unique case (dsmb_mode_t'(opMode))
      DSMB_MODE_POS: begin
        next_r.statusWord[DSMB_SW_TOL]     = ~ferrWinIf.held;
        next_r.statusWord[DSMB_SW_TARGET]  = taskDone & inPosWin;
        next_r.statusWord[DSMB_SW_HOME]    = homeValid;
        next_r.statusWord[DSMB_SW_ACK]     = next_r.ackBit;
        next_r.statusWord[DSMB_SW_STOPPED] = ~(taskActive & (actVel != 0));
        next_r.statusWord[DSMB_SW_LIM_POS] = limitAny;
      end
      DSMB_MODE_VEL: begin
        next_r.statusWord[DSMB_SW_TOL]     = velWinIf.held;
        next_r.statusWord[DSMB_SW_TARGET]  = (actVel >= $signed(r.velThr));
        next_r.statusWord[DSMB_SW_LIM_OTH] = limitAny;
      end
      DSMB_MODE_TRQ: begin
        if (safetyStopRequest) begin
          next_r.statusWord[DSMB_SW_TARGET] = 1'b0;
        end else if (halt) begin
          next_r.statusWord[DSMB_SW_TARGET] = axisStopped;
        end else begin
          next_r.statusWord[DSMB_SW_TARGET] = torqueReached;
        end
        next_r.statusWord[DSMB_SW_LIM_OTH] = limitAny;
      end
      DSMB_MODE_NONE: begin
        next_r.statusWord = '0;
      end
    endcase

    // interrupt events: edges of the reported bits
    if (dsmb_mode_t'(opMode) == DSMB_MODE_POS) begin
      irqEvent[DSMB_IRQ_FERR]   = r.statusWord[DSMB_SW_TOL] & ~next_r.statusWord[DSMB_SW_TOL];
      irqEvent[DSMB_IRQ_TARGET] = ~r.statusWord[DSMB_SW_TARGET] & next_r.statusWord[DSMB_SW_TARGET];
      irqEvent[DSMB_IRQ_ACK]    = ~r.statusWord[DSMB_SW_ACK] & next_r.statusWord[DSMB_SW_ACK];
    end
    irqEvent[DSMB_IRQ_LIMIT] = limitAny & ~r.limPrev;
    next_r.limPrev           = limitAny;

    // register writes take effect in the access phase
    if (apbWrite) begin
      unique case (paddr)
        DSMB_OFF_FERR_WIN: next_r.ferrWin = pwdata;
        DSMB_OFF_FERR_TMO: next_r.ferrTmo = pwdata;
        DSMB_OFF_POS_WIN:  next_r.posWin  = pwdata;
        DSMB_OFF_VEL_WIN:  next_r.velWin  = pwdata;
        DSMB_OFF_VEL_TIME: next_r.velTime = pwdata;
        DSMB_OFF_VEL_THR:  next_r.velThr  = pwdata;
        DSMB_OFF_IRQ_CLR:  irqClr         = pwdata[DSMB_IRQ_N-1:0];
        DSMB_OFF_IRQ_EN:   next_r.irqEn   = pwdata[DSMB_IRQ_N-1:0];
        default: ;
      endcase
    end
    // an event in the clearing cycle stays set
    next_r.irqSts = (r.irqSts & ~irqClr) | irqEvent;

    // read data and error are captured in the setup phase
    if (apbSetup) begin
      next_r.rdErr  = 1'b0;
      next_r.rdData = '0;
      unique case (paddr)
        DSMB_OFF_STATUS:   next_r.rdData = {16'h0000, r.statusWord};
        DSMB_OFF_FERR_WIN: next_r.rdData = r.ferrWin;
        DSMB_OFF_FERR_TMO: next_r.rdData = r.ferrTmo;
        DSMB_OFF_POS_WIN:  next_r.rdData = r.posWin;
        DSMB_OFF_VEL_WIN:  next_r.rdData = r.velWin;
        DSMB_OFF_VEL_TIME: next_r.rdData = r.velTime;
        DSMB_OFF_VEL_THR:  next_r.rdData = r.velThr;
        DSMB_OFF_IRQ_STS:  next_r.rdData = {28'h0000000, r.irqSts};
        DSMB_OFF_IRQ_CLR:  next_r.rdData = '0;
        DSMB_OFF_IRQ_EN:   next_r.rdData = {28'h0000000, r.irqEn};
        default:           next_r.rdErr  = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r         <= '0;
      r.ferrWin <= DSMB_RST_FERR_WIN;
      r.ferrTmo <= DSMB_RST_FERR_TMO;
      r.posWin  <= DSMB_RST_POS_WIN;
      r.velWin  <= DSMB_RST_VEL_WIN;
      r.velTime <= DSMB_RST_VEL_TIME;
      r.velThr  <= DSMB_RST_VEL_THR;
      r.irqEn   <= DSMB_RST_IRQ_EN;
    end else begin
      r <= next_r;
    end
  end

  assign prdata          = r.rdData;
  assign pready          = penable;
  assign pslverr         = psel & penable & r.rdErr;
  assign driveStatusWord = r.statusWord;
  assign irq             = |(r.irqSts & r.irqEn);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_ferr_out;
    (opMode == DSMB_MODE_POS) && ferrWinIf.held |=> !driveStatusWord[DSMB_SW_TOL];
  endproperty
  a_ferr_out: assert property (p_ferr_out) else $error("bit 8 high with following error held");

  property p_target;
    (opMode == DSMB_MODE_POS) && taskDone && inPosWin |=> driveStatusWord[DSMB_SW_TARGET];
  endproperty
  a_target: assert property (p_target) else $error("target reached not shown");

  property p_home;
    (opMode == DSMB_MODE_POS) && !homeValid |=> !driveStatusWord[DSMB_SW_HOME];
  endproperty
  a_home: assert property (p_home) else $error("home bit set without valid home");

  property p_ack_cause;
    $rose(r.ackBit) |-> $past(cw6Fall) && $past(r.ackArmed);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge rose without armed falling edge");

  property p_ack_off;
    !inOperation |=> !driveStatusWord[DSMB_SW_ACK] && !r.ackArmed;
  endproperty
  a_ack_off: assert property (p_ack_off) else $error("acknowledge survived leaving operation");

  property p_moving;
    (opMode == DSMB_MODE_POS) && taskActive && (actVel != 0) |=> !driveStatusWord[DSMB_SW_STOPPED];
  endproperty
  a_moving: assert property (p_moving) else $error("stopped bit high while moving");

  property p_limit_vel;
    (opMode == DSMB_MODE_VEL) && limitAny |=> driveStatusWord[DSMB_SW_LIM_OTH] && !driveStatusWord[DSMB_SW_LIM_POS];
  endproperty
  a_limit_vel: assert property (p_limit_vel) else $error("limit not on bit 11 in velocity mode");

  property p_speed_tol;
    (opMode == DSMB_MODE_VEL) && velWinIf.held |=> driveStatusWord[DSMB_SW_TOL];
  endproperty
  a_speed_tol: assert property (p_speed_tol) else $error("speed in tolerance not shown");

  property p_threshold;
    (opMode == DSMB_MODE_VEL) |=> driveStatusWord[DSMB_SW_TARGET] == ($past(actVel) >= $signed($past(r.velThr)));
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold bit wrong");

  property p_halt_stop;
    (opMode == DSMB_MODE_TRQ) && !safetyStopRequest && halt && axisStopped |=> driveStatusWord[DSMB_SW_TARGET];
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("stopped axis under halt not shown");

  property p_safety;
    (opMode == DSMB_MODE_TRQ) && safetyStopRequest |=> !driveStatusWord[DSMB_SW_TARGET];
  endproperty
  a_safety: assert property (p_safety) else $error("bit 10 high during safety stop");

  property p_reserved;
    (opMode != DSMB_MODE_POS) |=> driveStatusWord[15:12] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set outside position mode");

  property p_set_wins;
    irqEvent[DSMB_IRQ_LIMIT] && irqClr[DSMB_IRQ_LIMIT] |=> r.irqSts[DSMB_IRQ_LIMIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("limit event lost to clear");

  property p_ack_set;
    (opMode == DSMB_MODE_POS) && inOperation && cw6Fall && r.ackArmed && r.ackPending
      |=> driveStatusWord[DSMB_SW_ACK];
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("acknowledge not set on armed falling edge");

  property p_home_set;
    (opMode == DSMB_MODE_POS) && homeValid |=> driveStatusWord[DSMB_SW_HOME];
  endproperty
  a_home_set: assert property (p_home_set) else $error("home bit clear with valid home");

  property p_trq_reach;
    (opMode == DSMB_MODE_TRQ) && !safetyStopRequest && !halt
      |=> driveStatusWord[DSMB_SW_TARGET] == $past(torqueReached);
  endproperty
  a_trq_reach: assert property (p_trq_reach) else $error("torque reached not shown");

endmodule

// file: tb/dsmb_ctrl_model.sv
// model: fieldbus controller side that writes the control word
`timescale 1ns/10ps
module dsmb_ctrl_model
  import dsmb_pkg::*;
(
  // clock
  input  wire logic        clk,
  // control word towards the drive
  output logic      [15:0] ctrlWord
);
  initial ctrlWord = 16'h0000;

  // slow adds idle cycles before the new level is applied
  task automatic set_task(input logic v, input int slow);
    repeat (slow) @(posedge clk);
    @(posedge clk);
    ctrlWord[DSMB_CW_TASK] <= v;
  endtask

  task automatic set_halt(input logic v);
    @(posedge clk);
    ctrlWord[DSMB_CW_HALT] <= v;
  endtask
endmodule

// file: tb/tb_drive_status_mode_bits.sv
// testbench: status word bits per mode, apb registers and interrupt
`timescale 1ns/10ps
module tb_drive_status_mode_bits
  import dsmb_pkg::*;
();
  logic               clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic [11:0]        paddr = 12'h000;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [1:0]         opMode = 2'h0;
  logic               inOperation = 1'b0;
  logic [15:0]        ctrlWord;
  logic signed [31:0] actPos = 32'sh0;
  logic signed [31:0] demandPos = 32'sh0;
  logic signed [31:0] targetPos = 32'sh0;
  logic signed [31:0] actVel = 32'sh0;
  logic signed [31:0] targetVel = 32'sh0;
  logic               taskActive = 1'b0;
  logic               taskDone = 1'b0;
  logic               taskAccepted = 1'b0;
  logic               homeValid = 1'b0;
  logic               torqueReached = 1'b0;
  logic               axisStopped = 1'b0;
  logic               safetyStopRequest = 1'b0;
  logic [3:0]         limSrc = 4'h0;
  logic [15:0]        driveStatusWord;
  logic               irq;
  logic [31:0]        rd;
  logic               er;
  int                 error_cnt = 0;
  int                 checked = 0;
  int                 cyc = 0;
  int                 seed = 32'h2d5b;
  int                 d;
  logic [1:0]         modes [3] = '{DSMB_MODE_POS, DSMB_MODE_VEL, DSMB_MODE_TRQ};
  logic [11:0]        regOff [7] = '{DSMB_OFF_FERR_WIN, DSMB_OFF_FERR_TMO, DSMB_OFF_POS_WIN, DSMB_OFF_VEL_WIN,
                                     DSMB_OFF_VEL_TIME, DSMB_OFF_VEL_THR, DSMB_OFF_IRQ_EN};
  logic [31:0]        regRst [7] = '{DSMB_RST_FERR_WIN, DSMB_RST_FERR_TMO, DSMB_RST_POS_WIN, DSMB_RST_VEL_WIN,
                                     DSMB_RST_VEL_TIME, DSMB_RST_VEL_THR, {28'h0, DSMB_RST_IRQ_EN}};

  always #10 clk = ~clk;

  dsmb_ctrl_model ctrl_u (.clk(clk), .ctrlWord(ctrlWord));

  dsmb_status_bits dut_u (
    .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .opMode(opMode),
    .inOperation(inOperation), .ctrlWord(ctrlWord), .actPos(actPos), .demandPos(demandPos),
    .targetPos(targetPos), .taskActive(taskActive), .taskDone(taskDone), .taskAccepted(taskAccepted),
    .homeValid(homeValid), .actVel(actVel), .targetVel(targetVel), .torqueReached(torqueReached),
    .axisStopped(axisStopped), .safetyStopRequest(safetyStopRequest), .swPosLimit(limSrc[0]),
    .posOvertravel(limSrc[1]), .negOvertravel(limSrc[2]), .torqueLimit(limSrc[3]),
    .driveStatusWord(driveStatusWord), .irq(irq));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no limit here: only the bench timeout ends a hung access
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("wait_states", 32'h0, n);
  endtask

  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp, input logic experr);
    apb(a, 1'b0, 32'h0);
    chk(name, exp, rd);
    chk("pslverr", {31'h0, experr}, {31'h0, er});
  endtask

  // task acknowledge handshake: rise, accepted pulse, fall
  task automatic ack_seq(input int slow);
    ctrl_u.set_task(1'b1, slow);
    @(posedge clk);
    taskAccepted <= 1'b1;
    @(posedge clk);
    taskAccepted <= 1'b0;
    ctrl_u.set_task(1'b0, slow);
    settle(2);
  endtask

  function automatic logic exp_target(input int dd, input logic done);
    return done && dd <= 16 && dd >= -16;
  endfunction

  function automatic logic exp_trq(input logic s, input logic h, input logic r, input logic st);
    return s ? 1'b0 : (h ? st : r);
  endfunction

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) rchk("reg", regOff[i], regRst[i], 1'b0);
    rchk("unmapped", 12'h030, 32'h0, 1'b1);
    rchk("irq_clr", DSMB_OFF_IRQ_CLR, 32'h0, 1'b0);
    apb(DSMB_OFF_IRQ_EN, 1'b1, 32'h0000_000F);
    rchk("irq_en", DSMB_OFF_IRQ_EN, 32'h0000_000F, 1'b0);
    apb(DSMB_OFF_IRQ_EN, 1'b1, 32'h0);
    $display("test registers done");
    @(posedge clk);
    opMode <= DSMB_MODE_POS;
    inOperation <= 1'b1;
    homeValid <= 1'b1;
    settle(2);
    chk("home", 32'h1, driveStatusWord[DSMB_SW_HOME]);
    rchk("status", DSMB_OFF_STATUS, 32'h0000_2900, 1'b0);
    @(posedge clk);
    homeValid <= 1'b0;
    settle(2);
    chk("home", 32'h0, driveStatusWord[DSMB_SW_HOME]);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      taskActive <= i[0];
      actVel <= i[1] ? 32'sh5 : 32'sh0;
      settle(2);
      chk("stopped", !(i[0] && i[1]), driveStatusWord[DSMB_SW_STOPPED]);
    end
    for (int i = 0; i < 12; i++) begin
      d = (i < 2) ? 16 + i : $random(seed) % 40;
      @(posedge clk);
      targetPos <= 32'sh1000 * i;
      actPos <= 32'sh1000 * i + d;
      demandPos <= 32'sh1000 * i + d;
      taskDone <= (i % 3 != 2);
      settle(2);
      chk("target", exp_target(d, i % 3 != 2), driveStatusWord[DSMB_SW_TARGET]);
    end
    $display("test position done");
    @(posedge clk);
    taskDone <= 1'b0;
    demandPos <= 32'sh0;
    actPos <= 32'sh101;
    settle(90);
    chk("ferr", 32'h1, driveStatusWord[DSMB_SW_TOL]);
    settle(20);
    chk("ferr", 32'h0, driveStatusWord[DSMB_SW_TOL]);
    @(posedge clk);
    actPos <= 32'sh100;
    settle(3);
    chk("ferr", 32'h1, driveStatusWord[DSMB_SW_TOL]);
    @(posedge clk);
    opMode <= DSMB_MODE_VEL;
    targetVel <= 32'sh100;
    // one cycle outside the window so the hold timer starts from zero
    actVel <= 32'sh0;
    @(posedge clk);
    actVel <= 32'sh0E0;
    settle(90);
    chk("speed_tol", 32'h0, driveStatusWord[DSMB_SW_TOL]);
    settle(20);
    chk("speed_tol", 32'h1, driveStatusWord[DSMB_SW_TOL]);
    @(posedge clk);
    actVel <= 32'sh0DF;
    settle(3);
    chk("speed_tol", 32'h0, driveStatusWord[DSMB_SW_TOL]);
    for (int i = 0; i < 10; i++) begin
      d = (i < 2) ? 63 + i : $random(seed) % 128;
      @(posedge clk);
      actVel <= d;
      settle(2);
      chk("threshold", d >= 64, driveStatusWord[DSMB_SW_TARGET]);
    end
    $display("test velocity done");
    @(posedge clk);
    opMode <= DSMB_MODE_TRQ;
    for (int i = 0; i < 16; i++) begin
      ctrl_u.set_halt(i[2]);
      safetyStopRequest <= i[3];
      torqueReached <= i[1];
      axisStopped <= i[0];
      settle(2);
      chk("torque", exp_trq(i[3], i[2], i[1], i[0]), driveStatusWord[DSMB_SW_TARGET]);
    end
    $display("test torque done");
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 5; s++) begin
        @(posedge clk);
        opMode <= modes[m];
        taskActive <= 1'b0;
        limSrc <= (s == 0) ? 4'h0 : (4'h1 << (s - 1));
        settle(2);
        if (m == 0) chk("limit", s != 0, driveStatusWord[DSMB_SW_LIM_POS]);
        else chk("limit", s != 0, driveStatusWord[DSMB_SW_LIM_OTH]);
        if (m != 0) chk("reserved", 32'h0, driveStatusWord[15:12] & 4'hB);
      end
    end
    $display("test limits done");
    @(posedge clk);
    opMode <= DSMB_MODE_POS;
    limSrc <= 4'h0;
    actPos <= 32'sh0;
    fork
      apb(DSMB_OFF_IRQ_CLR, 1'b1, 32'h0000_000F);
      begin
        // limit rises in the clearing access cycle: the set must win
        repeat (2) @(posedge clk);
        limSrc <= 4'h2;
      end
    join
    ack_seq(0);
    chk("ack", 32'h1, driveStatusWord[DSMB_SW_ACK]);
    chk("irq", 32'h0, irq);
    apb(DSMB_OFF_IRQ_STS, 1'b0, 32'h0);
    chk("irq_sts", 32'h4, rd & 32'h4);
    chk("irq_set_wins", 32'h8, rd & 32'h8);
    apb(DSMB_OFF_IRQ_EN, 1'b1, 32'h0000_0004);
    settle(2);
    chk("irq", 32'h1, irq);
    apb(DSMB_OFF_IRQ_CLR, 1'b1, 32'h0000_0004);
    settle(2);
    chk("irq", 32'h0, irq);
    @(posedge clk);
    inOperation <= 1'b0;
    settle(2);
    chk("ack", 32'h0, driveStatusWord[DSMB_SW_ACK]);
    // request raised while still outside operation must not rearm
    ctrl_u.set_task(1'b1, 0);
    @(posedge clk);
    inOperation <= 1'b1;
    @(posedge clk);
    taskAccepted <= 1'b1;
    @(posedge clk);
    taskAccepted <= 1'b0;
    ctrl_u.set_task(1'b0, 1);
    settle(2);
    chk("ack", 32'h0, driveStatusWord[DSMB_SW_ACK]);
    ack_seq(2);
    chk("ack", 32'h1, driveStatusWord[DSMB_SW_ACK]);
    ctrl_u.set_task(1'b1, 0);
    settle(2);
    chk("ack", 32'h0, driveStatusWord[DSMB_SW_ACK]);
    $display("test acknowledge done");
    print_verdict();
  end
endmodule
